// File: src/ivl_clkgate.sv
// Purpose: maps the operating mode onto clock and oscillator enables
// Assumes: mode is registered by the caller
// Notes: output is registered so the top drives it from a flip-flop
`include "ivl_defs.svh"
module ivl_clkgate
   import ivl_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control
   input wire ivl_mode_t mode,
   input wire logic dco_is_active_src,
   // enables
   output ivl_clk_t clk_en
);
   ivl_clk_t next_clk_en;

   always_comb
   begin
      next_clk_en = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      case (mode)
         IVL_ACTIVE: ; // see (R12)
         IVL_SLEEP0:
         begin
            next_clk_en.cpu_run = 1'b0; // see (R13)
            next_clk_en.main_clk_en = 1'b0;
         end
         IVL_SLEEP1:
         begin
            next_clk_en.cpu_run = 1'b0; // see (R14)
            next_clk_en.main_clk_en = 1'b0;
            next_clk_en.dco_dc_en = dco_is_active_src;
         end
         IVL_SLEEP2:
         begin
            next_clk_en.cpu_run = 1'b0; // see (R15)
            next_clk_en.main_clk_en = 1'b0;
            next_clk_en.sub_clk_en = 1'b0;
         end
         IVL_SLEEP3:
         begin
            next_clk_en.cpu_run = 1'b0; // see (R16)
            next_clk_en.main_clk_en = 1'b0;
            next_clk_en.sub_clk_en = 1'b0;
            next_clk_en.dco_dc_en = 1'b0;
         end
         default:
         begin
            next_clk_en = '0; // see (R17)
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         clk_en <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      else
         clk_en <= next_clk_en;
   end
endmodule

// File: src/ivl_ctrl.sv
// Function
// (R1) vectors live in top sixteen words
// (R2) each vector word holds handler address
// (R3) all reset causes take top vector
// (R4) nmi, osc fault, access fault share vector
// (R5) timer channel 0 has own vector
// (R6) channels 1, 2, overflow share vector
// (R7) eight port 2 flags share vector
// (R8) port 1 vector just below port 2
// (R9) handler must find shared-vector source
// (R10) one pin is reset or nmi
// (R11) any interrupt wakes, return restores sleep
// (R12) active mode runs every clock
// (R13) sleep 0 stops cpu and main clock
// (R14) sleep 1 also drops unused dco dc
// (R15) sleep 2 stops main and sub clocks
// (R16) sleep 3 leaves only auxiliary clock
// (R17) sleep 4 stops all clocks, crystal
// (R18) nmi group: own enables, not global
// (R19) timer/port flags held in peripherals
// (R20) highest pending enabled priority wins
// Purpose: vector selection, fetch address and low-power mode control
// Assumes: APB slave, cpu handshakes with take/ret strobes
// Notes: nmi flags are sticky here; peripheral flags are levels
//
// Implementation choices: the APB slave port and the register addresses.
`include "ivl_defs.svh"
module ivl_ctrl
   import ivl_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset sources and nmi pin
   input wire logic power_up,
   input wire logic watchdog_expiry_flag,
   input wire logic flash_key_violation_flag,
   input wire logic reset_nmi_pin,
   // nmi group sources
   input wire logic oscillator_fault_flag,
   input wire logic flash_access_violation_flag,
   // maskable sources, flags kept inside peripherals
   input wire logic comparator_flag,
   input wire logic watchdog_interval_flag,
   input wire logic timer_channel0_flag,
   input wire logic timer_channel1_flag,
   input wire logic timer_channel2_flag,
   input wire logic timer_overflow_flag,
   input wire logic [7:0] port2_pin_flags,
   input wire logic [7:0] port1_pin_flags,
   // cpu handshake
   input wire logic irq_take,
   input wire logic irq_return,
   output logic irq_req,
   output logic [15:0] vector_addr,
   output logic [15:0] handler_addr,
   output logic system_reset,
   // clock control
   output ivl_clk_t clk_en
);
   localparam int NVEC = 16;
   localparam logic [5:0] VTAB_PAGE = 6'(`IVL_OFF_VTAB >> 6);

   logic [31:0] ctrl;
   logic [2:0] nmi_en;
   logic [2:0] nmi_flags;
   logic [15:0] vtab [NVEC];
   ivl_mode_t mode;
   ivl_mode_t saved_mode;
   logic in_handler;
   logic [31:0] next_ctrl;
   logic [2:0] next_nmi_en;
   logic [2:0] next_nmi_flags;
   logic [15:0] next_vtab [NVEC];
   ivl_mode_t next_mode;
   ivl_mode_t next_saved_mode;
   logic next_in_handler;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic next_irq_req;
   logic [15:0] next_vector_addr;
   logic [15:0] next_handler_addr;
   logic next_system_reset;
   logic [3:0] win_pri;
   logic any_req;
   logic pin_nmi_edge;
   logic pin_last;
   logic wr_en;
   logic rd_en;
   logic setup_wr;

   function automatic logic [15:0] vec_of(input logic [3:0] pri);
      vec_of = `IVL_VEC_BASE + {11'h000, pri, 1'b0}; // see (R1)
   endfunction

   function automatic ivl_mode_t mode_of(input logic [2:0] code);
      case (code)
         3'h1: mode_of = IVL_SLEEP0;
         3'h2: mode_of = IVL_SLEEP1;
         3'h3: mode_of = IVL_SLEEP2;
         3'h4: mode_of = IVL_SLEEP3;
         3'h5: mode_of = IVL_SLEEP4;
         default: mode_of = IVL_ACTIVE;
      endcase
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `IVL_OFF_CTRL) || (a == `IVL_OFF_NMIEN) || (a == `IVL_OFF_STAT)
         || (a[11:6] == VTAB_PAGE);
   endfunction

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   // error must stand with pready, so it is decoded in the setup cycle
   assign setup_wr = psel & ~penable & pwrite;
   assign pin_nmi_edge = ctrl[`IVL_CTRL_NMIPIN] & reset_nmi_pin & ~pin_last; // see (R10)

   // fixed priority; shared vectors never say which source fired, see (R9)
   always_comb
   begin
      win_pri = 4'h0;
      any_req = 1'b1;
      if (|(nmi_flags & nmi_en))
         win_pri = `IVL_PRI_NMI; // see (R4) (R18)
      else if (!ctrl[`IVL_CTRL_GIE] || in_handler)
         any_req = 1'b0; // see (R20)
      else if (comparator_flag)
         win_pri = `IVL_PRI_COMP;
      else if (watchdog_interval_flag)
         win_pri = `IVL_PRI_WDT;
      else if (timer_channel0_flag)
         win_pri = `IVL_PRI_TCH0; // see (R5)
      else if (timer_channel1_flag | timer_channel2_flag | timer_overflow_flag)
         win_pri = `IVL_PRI_TSHR; // see (R6) (R19)
      else if (|port2_pin_flags)
         win_pri = `IVL_PRI_PORT2; // see (R7)
      else if (|port1_pin_flags)
         win_pri = `IVL_PRI_PORT1; // see (R8)
      else
         any_req = 1'b0;
   end

   always_comb
   begin
      next_ctrl = ctrl;
      next_nmi_en = nmi_en;
      next_nmi_flags = nmi_flags;
      next_vtab = vtab;
      next_mode = mode;
      next_saved_mode = saved_mode;
      next_in_handler = in_handler;
      next_prdata = prdata;
      next_pslverr = setup_wr & ~is_mapped(paddr);
      next_irq_req = any_req & ~irq_take;
      next_vector_addr = any_req ? vec_of(win_pri) : vector_addr;
      next_handler_addr = any_req ? vtab[win_pri] : handler_addr; // see (R2)
      next_system_reset = power_up | watchdog_expiry_flag | flash_key_violation_flag
         | (~ctrl[`IVL_CTRL_NMIPIN] & reset_nmi_pin); // see (R3) (R10)
      if (wr_en)
      begin
         if (paddr == `IVL_OFF_CTRL)
         begin
            next_ctrl = pwdata & 32'h0000_0077;
            next_mode = mode_of(pwdata[`IVL_CTRL_SLEEP_LO +: 3]);
         end
         else if (paddr == `IVL_OFF_NMIEN)
            next_nmi_en = pwdata[2:0];
         else if (paddr == `IVL_OFF_STAT)
            next_nmi_flags = nmi_flags & ~pwdata[2:0];
         else if (paddr[11:6] == VTAB_PAGE)
            next_vtab[paddr[5:2]] = pwdata[15:0];
      end
      if (rd_en)
      begin
         if (paddr == `IVL_OFF_CTRL)
            next_prdata = {25'h000_0000, ctrl[6:4] & 3'h7, 1'b0, ctrl[2:0]};
         else if (paddr == `IVL_OFF_NMIEN)
            next_prdata = {29'h0000_0000, nmi_en};
         else if (paddr == `IVL_OFF_STAT)
            next_prdata = {24'h00_0000, 1'b0, mode, in_handler, nmi_flags};
         else if (paddr[11:6] == VTAB_PAGE)
            next_prdata = {16'h0000, vtab[paddr[5:2]]};
         else
            next_prdata = 32'h0000_0000;
      end
      // set wins over a software clear in the same cycle
      next_nmi_flags = next_nmi_flags
         | {flash_access_violation_flag, oscillator_fault_flag, pin_nmi_edge};
      // wake on take, remember the sleep level for the return
      if (irq_take && any_req)
      begin
         next_saved_mode = next_mode; // see (R11)
         next_mode = IVL_ACTIVE;
         next_in_handler = 1'b1;
         if (win_pri == `IVL_PRI_NMI)
            next_ctrl[`IVL_CTRL_GIE] = 1'b0;
      end
      else if (irq_return && in_handler)
      begin
         next_mode = saved_mode; // see (R11)
         next_in_handler = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ctrl <= `IVL_CTRL_RST;
         nmi_en <= 3'h0;
         nmi_flags <= 3'h0;
         for (int i = 0; i < NVEC; i++)
            vtab[i] <= `IVL_VTAB_RST;
         mode <= IVL_ACTIVE;
         saved_mode <= IVL_ACTIVE;
         in_handler <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
         irq_req <= 1'b0;
         vector_addr <= `IVL_VEC_RESET;
         handler_addr <= 16'h0000;
         system_reset <= 1'b1;
         pin_last <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         nmi_en <= next_nmi_en;
         nmi_flags <= next_nmi_flags;
         vtab <= next_vtab;
         mode <= next_system_reset ? IVL_ACTIVE : next_mode;
         saved_mode <= next_saved_mode;
         in_handler <= next_system_reset ? 1'b0 : next_in_handler;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         pready <= psel & ~penable;
         irq_req <= next_irq_req;
         vector_addr <= next_system_reset ? `IVL_VEC_RESET : next_vector_addr; // see (R3)
         handler_addr <= next_system_reset ? vtab[NVEC-1] : next_handler_addr;
         system_reset <= next_system_reset;
         pin_last <= reset_nmi_pin;
      end
   end

   ivl_clkgate u_clkgate
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .mode(mode),
      .dco_is_active_src(ctrl[`IVL_CTRL_DCOACT]),
      .clk_en(clk_en)
   );

   a_nmi_vec: assert property (@(posedge clk_sys) disable iff (rst) // see (R4)
      (|(nmi_flags & nmi_en) && !next_system_reset) |=> vector_addr == `IVL_VEC_NMI)
      else $error("nmi group did not select its vector");
   a_gie_block: assert property (@(posedge clk_sys) disable iff (rst) // see (R20)
      (!ctrl[`IVL_CTRL_GIE] && !(|(nmi_flags & nmi_en))) |-> !any_req)
      else $error("maskable request passed with global enable off");
   a_reset_vec: assert property (@(posedge clk_sys) disable iff (rst) // see (R3)
      watchdog_expiry_flag |=> system_reset && vector_addr == `IVL_VEC_RESET)
      else $error("watchdog did not force reset vector");
   a_port_rank: assert property (@(posedge clk_sys) disable iff (rst) // see (R8)
      (any_req && win_pri == `IVL_PRI_PORT1) |-> port2_pin_flags == 8'h00)
      else $error("port 1 won over port 2");
   sequence s_take_sleep;
      !in_handler && mode != IVL_ACTIVE && irq_take && any_req && !next_system_reset;
   endsequence
   a_wake_act: assert property (@(posedge clk_sys) disable iff (rst) // see (R11)
      s_take_sleep |=> mode == IVL_ACTIVE ##2 clk_en.cpu_run)
      else $error("interrupt did not wake the cpu");
   a_ret_mode: assert property (@(posedge clk_sys) disable iff (rst) // see (R11)
      (irq_return && in_handler && !irq_take && !next_system_reset)
      |=> mode == $past(saved_mode))
      else $error("return did not restore sleep level");
   a_sleep4_off: assert property (@(posedge clk_sys) disable iff (rst) // see (R17)
      mode == IVL_SLEEP4 |=> clk_en == '0)
      else $error("sleep 4 left a clock running");
   a_sleep3_aux: assert property (@(posedge clk_sys) disable iff (rst) // see (R16)
      mode == IVL_SLEEP3 |=> clk_en.aux_clk_en && !clk_en.sub_clk_en && !clk_en.dco_dc_en)
      else $error("sleep 3 clock set wrong");
   a_nmi_sticky: assert property (@(posedge clk_sys) disable iff (rst) // see (R18)
      oscillator_fault_flag |=> nmi_flags[1])
      else $error("oscillator fault flag lost");
endmodule

// File: src/ivl_defs.svh
// Purpose: constants for the interrupt vector and low-power controller
// Assumes: 16-bit byte addresses, 32-bit APB data, one register per word
// Notes: offsets are byte addresses on the APB
`ifndef IVL_DEFS_SVH
`define IVL_DEFS_SVH

`define IVL_VEC_TOP 16'hFFFF
`define IVL_VEC_BASE 16'hFFE0
`define IVL_VEC_RESET 16'hFFFE
`define IVL_VEC_NMI 16'hFFFC
`define IVL_VEC_COMP 16'hFFF6
`define IVL_VEC_WDT 16'hFFF4
`define IVL_VEC_TCH0 16'hFFF2
`define IVL_VEC_TSHR 16'hFFF0
`define IVL_VEC_PORT2 16'hFFE6
`define IVL_VEC_PORT1 16'hFFE4

`define IVL_PRI_RESET 4'hF
`define IVL_PRI_NMI 4'hE
`define IVL_PRI_COMP 4'hB
`define IVL_PRI_WDT 4'hA
`define IVL_PRI_TCH0 4'h9
`define IVL_PRI_TSHR 4'h8
`define IVL_PRI_PORT2 4'h3
`define IVL_PRI_PORT1 4'h2

`define IVL_OFF_CTRL 12'h000
`define IVL_OFF_NMIEN 12'h004
`define IVL_OFF_STAT 12'h008
`define IVL_OFF_VTAB 12'h040

`define IVL_CTRL_GIE 0
`define IVL_CTRL_NMIPIN 1
`define IVL_CTRL_DCOACT 2
`define IVL_CTRL_SLEEP_LO 4

`define IVL_CTRL_RST 32'h0000_0000
`define IVL_NMIEN_RST 32'h0000_0000
`define IVL_VTAB_RST 16'h0000

`endif

// File: src/ivl_pkg.sv
// Purpose: types for the interrupt vector and low-power controller
// Assumes: included defs give all numbers
// Notes: none
package ivl_pkg;
   typedef enum logic [2:0]
   {
      IVL_ACTIVE,
      IVL_SLEEP0,
      IVL_SLEEP1,
      IVL_SLEEP2,
      IVL_SLEEP3,
      IVL_SLEEP4
   } ivl_mode_t;

   typedef struct packed
   {
      logic cpu_run;
      logic main_clk_en;
      logic sub_clk_en;
      logic aux_clk_en;
      logic dco_dc_en;
      logic xtal_en;
   } ivl_clk_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ivl_apb_req_t;
endpackage

// File: tb/ivl_cpu_model.sv
// Purpose: cpu side of the vector handshake
// Assumes: take is one pulse, return one pulse after a fixed handler time
// Notes: lat sets how long the cpu dawdles before it takes a request
module ivl_cpu_model
#(
   parameter int HOLD = 8
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // handshake
   input wire logic irq_req,
   input wire logic [3:0] lat,
   output logic irq_take,
   output logic irq_return
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic busy;
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irq_take <= 1'h0;
         irq_return <= 1'h0;
         cnt <= 0;
         busy <= 1'h0;
      end
      else
      begin
         irq_take <= 1'h0;
         irq_return <= 1'h0;
         cnt <= cnt + 1;
         if (!busy && irq_req !== 1'h1)
            cnt <= 0;
         else if (!busy && cnt >= int'(lat))
         begin
            irq_take <= 1'h1;
            busy <= 1'h1;
            cnt <= 0;
         end
         else if (busy && cnt == HOLD)
         begin
            irq_return <= 1'h1;
            busy <= 1'h0;
            cnt <= 0;
         end
      end
   end
endmodule

// File: tb/test_irq_vector_lowpower_ctrl.sv
// Purpose: self-checking bench for the vector and low-power controller
// Assumes: bench plays the peripherals, a cpu model answers requests
// Notes: reset causes run last since they restart the block
`include "ivl_defs.svh"
module test_irq_vector_lowpower_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import ivl_pkg::*;
   logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic power_up = 1'h0, watchdog_expiry_flag = 1'h0, flash_key_violation_flag = 1'h0;
   logic reset_nmi_pin = 1'h0, oscillator_fault_flag = 1'h0, flash_access_violation_flag = 1'h0;
   logic comparator_flag = 1'h0, watchdog_interval_flag = 1'h0, timer_channel0_flag = 1'h0;
   logic timer_channel1_flag = 1'h0, timer_channel2_flag = 1'h0, timer_overflow_flag = 1'h0;
   logic [7:0] port2_pin_flags = 8'h00, port1_pin_flags = 8'h00, src, pb;
   logic [3:0] lat = 4'h0;
   logic er;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, irq_take, irq_return, irq_req, system_reset;
   wire logic [15:0] vector_addr, handler_addr;
   ivl_clk_t clk_en;
   logic [15:0] hv [16];
   logic [15:0] vt [8] = '{`IVL_VEC_PORT1, `IVL_VEC_PORT2, `IVL_VEC_TSHR, `IVL_VEC_TSHR,
      `IVL_VEC_TSHR, `IVL_VEC_TCH0, `IVL_VEC_WDT, `IVL_VEC_COMP};
   int n_errors = 0, samples_checked = 0, seed = 32'hbba4_1f93;

   always #20 clk_sys = ~clk_sys;

   ivl_ctrl dut(.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .power_up, .watchdog_expiry_flag, .flash_key_violation_flag, .reset_nmi_pin,
      .oscillator_fault_flag, .flash_access_violation_flag, .comparator_flag,
      .watchdog_interval_flag, .timer_channel0_flag, .timer_channel1_flag,
      .timer_channel2_flag, .timer_overflow_flag, .port2_pin_flags, .port1_pin_flags,
      .irq_take, .irq_return, .irq_req, .vector_addr, .handler_addr, .system_reset, .clk_en);
   ivl_cpu_model cpu(.clk_sys, .rst, .irq_req, .lat, .irq_take, .irq_return);

   task stop_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      @(posedge clk_sys);
      for (k = 0; k < 20 && pready !== 1'h1; k++)
         @(posedge clk_sys);
      if (pready !== 1'h1)
      begin
         n_errors++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // 0 request, 1 take, 2 return
   task wait_hi(input int s);
      int k;
      for (k = 0; k < 64; k++)
      begin
         @(posedge clk_sys);
         if ((s == 0 && irq_req === 1'h1) || (s == 1 && irq_take === 1'h1)
            || (s == 2 && irq_return === 1'h1))
            return;
      end
      n_errors++;
      stop_test();
   endtask

   function automatic logic [31:0] ctrl(input int m, input int d, input int p, input int g);
      return {25'h000_0000, 3'(m), 1'h0, 1'(d), 1'(p), 1'(g)};
   endfunction

   function automatic logic [5:0] exp_clk(input int m, input int d);
      case (m)
         0: return 6'h3F;
         1: return 6'h0F;
         2: return {4'h3, 1'(d), 1'h1};
         3: return 6'h07;
         4: return 6'h05;
         default: return 6'h00;
      endcase
   endfunction

   initial
   begin
      int i, m, d, w, k;
      logic [15:0] e;
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
      chk(clk_en, 6'h3F);
      for (i = 0; i < 16; i++)
      begin
         apb(1'h0, `IVL_OFF_VTAB + 12'(4 * i), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
         hv[i] = 16'($random(seed));
         apb(1'h1, `IVL_OFF_VTAB + 12'(4 * i), {16'h0000, hv[i]});
         apb(1'h0, `IVL_OFF_VTAB + 12'(4 * i), 32'h0000_0000);
         chk(rd, {16'h0000, hv[i]});
      end
      apb(1'h1, 12'h100, 32'hFFFF_FFFF);
      chk(er, 1'h1);
      apb(1'h0, 12'h100, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      for (d = 0; d < 2; d++)
         for (m = 0; m < 6; m++)
         begin
            apb(1'h1, `IVL_OFF_CTRL, ctrl(m, d, 0, 0));
            repeat (3) @(posedge clk_sys);
            chk(clk_en, exp_clk(m, d));
         end
      apb(1'h1, `IVL_OFF_CTRL, ctrl(0, 0, 0, 0));
      comparator_flag <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk(irq_req, 1'h0);
      for (w = 0; w < 14; w++)
      begin
         src = (w < 8) ? 8'h01 << w : 8'($random(seed)) | 8'h01;
         pb = 8'h01 << (w % 8);
         lat <= 4'(w % 5);
         apb(1'h1, `IVL_OFF_CTRL, ctrl(0, 0, 0, 1));
         {comparator_flag, watchdog_interval_flag, timer_channel0_flag} <= src[7:5];
         {timer_channel1_flag, timer_channel2_flag, timer_overflow_flag} <= src[4:2];
         port2_pin_flags <= src[1] ? pb : 8'h00;
         port1_pin_flags <= src[0] ? pb : 8'h00;
         for (i = 0; i < 8; i++)
            if (src[i])
               e = vt[i];
         wait_hi(0);
         chk(vector_addr, e);
         chk(handler_addr, hv[(e - `IVL_VEC_BASE) >> 1]);
         wait_hi(1);
         // handler clears its own sources
         {comparator_flag, watchdog_interval_flag, timer_channel0_flag} <= 3'h0;
         {timer_channel1_flag, timer_channel2_flag, timer_overflow_flag} <= 3'h0;
         port2_pin_flags <= 8'h00;
         port1_pin_flags <= 8'h00;
         wait_hi(2);
      end
      apb(1'h1, `IVL_OFF_CTRL, ctrl(4, 0, 0, 1));
      timer_channel0_flag <= 1'h1;
      wait_hi(1);
      timer_channel0_flag <= 1'h0;
      repeat (3) @(posedge clk_sys);
      chk(clk_en, 6'h3F);
      wait_hi(2);
      repeat (3) @(posedge clk_sys);
      chk(clk_en, exp_clk(4, 0));
      apb(1'h1, `IVL_OFF_CTRL, ctrl(0, 0, 0, 0));
      apb(1'h1, `IVL_OFF_NMIEN, 32'h0000_0000);
      for (k = 0; k < 3; k++)
      begin
         // pin must act as nmi before it rises, or it resets the block
         if (k == 0)
            apb(1'h1, `IVL_OFF_CTRL, ctrl(0, 0, 1, 0));
         oscillator_fault_flag <= (k == 1);
         flash_access_violation_flag <= (k == 2);
         reset_nmi_pin <= (k == 0);
         repeat (4) @(posedge clk_sys);
         chk(irq_req, 1'h0);
         apb(1'h1, `IVL_OFF_NMIEN, 32'h0000_0001 << k);
         wait_hi(0);
         chk(vector_addr, `IVL_VEC_NMI);
         wait_hi(1);
         {oscillator_fault_flag, flash_access_violation_flag, reset_nmi_pin} <= 3'h0;
         apb(1'h0, `IVL_OFF_STAT, 32'h0000_0000);
         chk(rd[3:0], 4'h8 | (4'h1 << k));
         chk(system_reset, 1'h0);
         apb(1'h1, `IVL_OFF_STAT, 32'h0000_0007);
         wait_hi(2);
         apb(1'h1, `IVL_OFF_NMIEN, 32'h0000_0000);
      end
      apb(1'h1, `IVL_OFF_CTRL, ctrl(0, 0, 0, 0));
      for (k = 0; k < 4; k++)
      begin
         {power_up, watchdog_expiry_flag, flash_key_violation_flag, reset_nmi_pin} <= 4'h8 >> k;
         repeat (3) @(posedge clk_sys);
         chk(system_reset, 1'h1);
         chk(vector_addr, `IVL_VEC_RESET);
         {power_up, watchdog_expiry_flag, flash_key_violation_flag, reset_nmi_pin} <= 4'h0;
         repeat (4) @(posedge clk_sys);
      end
      stop_test();
   end
endmodule
